/* verilog/tdcc_timer.sv */
// Dual capture/compare 16-bit timer with AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 16-bit read-only counter increments on count clock
// - Counter read freezes count clock for snapshot
// - Reset or stop mode clears counter
// - Edge-clear mode clears on first input edge
// - Match-clear mode clears on first register match
// - Control bit 0 selects first compare/capture
// - First compare match raises first interrupt
// - First pin edge code sets both capture triggers
// - Second pin edge code sets first capture trigger
// - Second-pin capture raises first interrupt
// - First-pin capture into first register: no interrupt
// - First register zero matches on counter wrap
// - Control bit 2 selects second compare/capture
// - Second compare match raises second interrupt
// - Second captures on first pin, raises interrupt
// - Compare registers reset zero, accept whole words only
// - Second register zero matches on counter wrap
// - Mode bits: stop, free, edge clear, match clear
// - Trigger select picks first register capture source
module tdcc_timer
  import tdcc_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Timer input pins
  input  wire logic              timer_input_first,
  input  wire logic              timer_input_second,
  // Interrupt pulses
  output logic                   match_first_irq,
  output logic                   match_second_irq
);

  typedef struct packed {
    // Bus slave
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    // Timer core
    tdcc_mode_t        mode;
    logic              first_cap_en;
    logic              first_trig_sel;
    logic              second_cap_en;
    tdcc_clksel_t      clk_sel;
    tdcc_edge_t        es_first;
    tdcc_edge_t        es_second;
    logic [1:0]        div;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  cc1;
    logic [CNT_W-1:0]  cc2;
    logic              irq1;
    logic              irq2;
  } tdcc_state_t;

  tdcc_state_t s_reg;
  tdcc_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Edge decoding helpers
  function automatic logic edge_valid(input tdcc_edge_t es, input logic rise,
                                      input logic fall);
    logic v;
    case (es)
      TDCC_EDGE_FALL: v = fall;
      TDCC_EDGE_RISE: v = rise;
      TDCC_EDGE_BOTH: v = rise | fall;
      default:        v = 1'b0;
    endcase
    return v;
  endfunction : edge_valid

  // Inverse of the valid edge; both-edge code yields no capture
  function automatic logic edge_inverted(input tdcc_edge_t es, input logic rise,
                                         input logic fall);
    logic v;
    case (es)
      TDCC_EDGE_FALL: v = rise;
      TDCC_EDGE_RISE: v = fall;
      default:        v = 1'b0;
    endcase
    return v;
  endfunction : edge_inverted

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  tdcc_edge_if pin_edges ();
  tdcc_pin_sync tdcc_pin_sync_inst (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .timer_input_first  (timer_input_first),
    .timer_input_second (timer_input_second),
    .edges              (pin_edges.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helper terms
  logic             aw_hs;
  logic             w_hs;
  logic             ar_hs;
  logic             wr_go;
  logic             rd_freeze;
  logic             running;
  logic             tick_src;
  logic             tick;
  logic             first_valid;
  logic             first_inv;
  logic             second_valid;
  logic             wrap_clear;
  logic [CNT_W-1:0] cnt_after;
  logic             match1;
  logic             match2;
  logic             cap1_evt;
  logic             cap2_evt;
  logic             word16;
  assign aw_hs  = awvalid & s_reg.awready;
  assign w_hs   = wvalid & s_reg.wready;
  assign ar_hs  = arvalid & s_reg.arready;
  assign wr_go  = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
  assign word16 = (s_reg.wstrb[1:0] == STRB_WORD16);
  // Freezing the count for the read cycle keeps the snapshot coherent
  assign rd_freeze = ar_hs & (araddr == ADDR_COUNT);
  assign running   = (s_reg.mode != TDCC_MODE_STOP);
  assign first_valid  = edge_valid(s_reg.es_first, pin_edges.rise[PIN_FIRST],
                                   pin_edges.fall[PIN_FIRST]);
  assign first_inv    = edge_inverted(s_reg.es_first, pin_edges.rise[PIN_FIRST],
                                      pin_edges.fall[PIN_FIRST]);
  assign second_valid = edge_valid(s_reg.es_second, pin_edges.rise[PIN_SECOND],
                                   pin_edges.fall[PIN_SECOND]);

  always_comb begin
    case (s_reg.clk_sel)
      TDCC_CLK_DIV1: tick_src = 1'b1;
      TDCC_CLK_DIV2: tick_src = s_reg.div[0];
      TDCC_CLK_DIV4: tick_src = &s_reg.div;
      default:       tick_src = first_valid;
    endcase
  end
  assign tick = running & tick_src & ~rd_freeze;
  // In match mode the count returns to zero after sitting on the first value
  assign wrap_clear = (s_reg.mode == TDCC_MODE_MATCH) && (s_reg.count == s_reg.cc1);
  assign cnt_after  = wrap_clear ? CNT_ZERO : s_reg.count + CNT_ONE;
  // Compare events fire on arrival, so a zero value fires on wrap
  assign match1 = tick & (cnt_after == s_reg.cc1);
  assign match2 = tick & (cnt_after == s_reg.cc2);
  assign cap1_evt = s_reg.first_cap_en &
                    (s_reg.first_trig_sel ? first_inv : second_valid);
  assign cap2_evt = s_reg.second_cap_en & first_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    // Write channels, taken in either order
    if (aw_hs) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (w_hs) begin
      s_next.w_got = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    // Counter
    s_next.div = running ? s_reg.div + 2'h1 : 2'h0;
    if (!running) begin
      s_next.count = CNT_ZERO;
    end else if (s_reg.mode == TDCC_MODE_EDGE && first_valid) begin
      s_next.count = CNT_ZERO;
    end else if (tick) begin
      s_next.count = cnt_after;
    end
    // Register writes; a capture in the same cycle wins over software
    if (wr_go) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      if (s_reg.awaddr == ADDR_CAPCMP1) begin
        if (word16) begin
          s_next.cc1 = s_reg.wdata[CNT_W-1:0];
        end else begin
          s_next.bresp = RESP_SLVERR;
        end
      end else if (s_reg.awaddr == ADDR_CAPCMP2) begin
        if (word16) begin
          s_next.cc2 = s_reg.wdata[CNT_W-1:0];
        end else begin
          s_next.bresp = RESP_SLVERR;
        end
      end else if (s_reg.awaddr == ADDR_MODE_CTRL) begin
        if (s_reg.wstrb[0]) begin
          s_next.mode = tdcc_mode_t'({s_reg.wdata[OP_MODE_HIGH_POS],
                                      s_reg.wdata[OP_MODE_LOW_POS]});
        end
      end else if (s_reg.awaddr == ADDR_CC_CTRL) begin
        if (s_reg.wstrb[0]) begin
          s_next.first_cap_en   = s_reg.wdata[FIRST_CAP_EN_POS];
          s_next.first_trig_sel = s_reg.wdata[FIRST_TRIG_POS];
          s_next.second_cap_en  = s_reg.wdata[SECOND_CAP_EN_POS];
        end
      end else if (s_reg.awaddr == ADDR_PRESCALE) begin
        if (s_reg.wstrb[0]) begin
          s_next.clk_sel   = tdcc_clksel_t'(s_reg.wdata[CLK_SEL_HI_POS:CLK_SEL_LO_POS]);
          s_next.es_first  = tdcc_edge_t'(s_reg.wdata[IN_FIRST_HI_POS:IN_FIRST_LO_POS]);
          s_next.es_second = tdcc_edge_t'(s_reg.wdata[IN_SECOND_HI_POS:IN_SECOND_LO_POS]);
        end
      end else if (s_reg.awaddr == ADDR_COUNT) begin
        s_next.bresp = RESP_SLVERR;
      end else begin
        s_next.bresp = RESP_DECERR;
      end
    end

    // Captures latch the pre-increment count
    if (cap1_evt) begin
      s_next.cc1 = s_reg.count;
    end
    if (cap2_evt) begin
      s_next.cc2 = s_reg.count;
    end
    // One-cycle interrupt pulses
    s_next.irq1 = (~s_reg.first_cap_en & match1) |
                  (s_reg.first_cap_en & ~s_reg.first_trig_sel & second_valid);
    s_next.irq2 = (~s_reg.second_cap_en & match2) | cap2_evt;

    // Read channel
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      s_next.rdata  = '0;
      if (araddr == ADDR_COUNT) begin
        s_next.rdata[CNT_W-1:0] = s_reg.count;
      end else if (araddr == ADDR_CAPCMP1) begin
        s_next.rdata[CNT_W-1:0] = s_reg.cc1;
      end else if (araddr == ADDR_CAPCMP2) begin
        s_next.rdata[CNT_W-1:0] = s_reg.cc2;
      end else if (araddr == ADDR_MODE_CTRL) begin
        s_next.rdata[OP_MODE_HIGH_POS] = s_reg.mode[1];
        s_next.rdata[OP_MODE_LOW_POS]  = s_reg.mode[0];
      end else if (araddr == ADDR_CC_CTRL) begin
        s_next.rdata[FIRST_CAP_EN_POS]  = s_reg.first_cap_en;
        s_next.rdata[FIRST_TRIG_POS]    = s_reg.first_trig_sel;
        s_next.rdata[SECOND_CAP_EN_POS] = s_reg.second_cap_en;
      end else if (araddr == ADDR_PRESCALE) begin
        s_next.rdata[CLK_SEL_HI_POS:CLK_SEL_LO_POS]     = s_reg.clk_sel;
        s_next.rdata[IN_FIRST_HI_POS:IN_FIRST_LO_POS]   = s_reg.es_first;
        s_next.rdata[IN_SECOND_HI_POS:IN_SECOND_LO_POS] = s_reg.es_second;
      end else begin
        s_next.rresp = RESP_DECERR;
      end
    end

    // One transaction per direction; ready drops while busy
    s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
    s_next.wready  = ~s_next.w_got & ~s_next.bvalid;
    s_next.arready = ~s_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready          = s_reg.awready;
  assign wready           = s_reg.wready;
  assign bvalid           = s_reg.bvalid;
  assign bresp            = s_reg.bresp;
  assign arready          = s_reg.arready;
  assign rvalid           = s_reg.rvalid;
  assign rdata            = s_reg.rdata;
  assign rresp            = s_reg.rresp;
  assign match_first_irq  = s_reg.irq1;
  assign match_second_irq = s_reg.irq2;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_stop_clears_count: assert property (
    s_reg.mode == TDCC_MODE_STOP |=> s_reg.count == CNT_ZERO)
    else $error("counter not cleared in stop mode");
  a_free_increments: assert property (
    (s_reg.mode == TDCC_MODE_FREE && tick) |=> s_reg.count == $past(s_reg.count) + CNT_ONE)
    else $error("counter did not increment on tick");
  a_read_snapshot: assert property (
    (s_reg.mode == TDCC_MODE_FREE && arvalid && arready && araddr == ADDR_COUNT)
    |=> (s_reg.count == $past(s_reg.count)) && rvalid && rdata[CNT_W-1:0] == s_reg.count)
    else $error("counter read was not a frozen snapshot");
  a_edge_mode_clear: assert property (
    (s_reg.mode == TDCC_MODE_EDGE && first_valid) |=> s_reg.count == CNT_ZERO)
    else $error("counter not cleared on first input edge");
  a_match_mode_clear: assert property (
    (s_reg.mode == TDCC_MODE_MATCH && tick && s_reg.count == s_reg.cc1)
    |=> s_reg.count == CNT_ZERO)
    else $error("counter not cleared on first register match");
  a_first_compare_irq: assert property (
    (s_reg.mode == TDCC_MODE_FREE && !s_reg.first_cap_en && tick
     && s_reg.count + CNT_ONE == s_reg.cc1) |=> match_first_irq && s_reg.count == s_reg.cc1)
    else $error("first compare match gave no interrupt");
  a_second_capture: assert property (
    (s_reg.second_cap_en && first_valid)
    |=> s_reg.cc2 == $past(s_reg.count) && match_second_irq)
    else $error("second capture missed value or interrupt");
  a_first_pin_quiet: assert property (
    (s_reg.first_cap_en && s_reg.first_trig_sel) |=> !match_first_irq)
    else $error("interrupt raised on first-pin capture");
  a_second_pin_irq: assert property (
    (s_reg.first_cap_en && !s_reg.first_trig_sel && second_valid)
    |=> match_first_irq && s_reg.cc1 == $past(s_reg.count))
    else $error("second-pin capture gave no interrupt");
  a_partial_write: assert property (
    (wr_go && s_reg.awaddr == ADDR_CAPCMP1 && !word16 && !cap1_evt)
    |=> s_reg.cc1 == $past(s_reg.cc1) && bresp == RESP_SLVERR)
    else $error("partial write altered first register");
endmodule : tdcc_timer
`default_nettype wire

/* shared/tdcc_pkg.sv */
// Constants, field layouts and encodings for the dual capture/compare timer
package tdcc_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_COUNT     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CAPCMP1   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CAPCMP2   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_CC_CTRL   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PRESCALE  = 8'h14;

  // Reset and boundary values of the counter
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

  // Field positions in mode_control_reg
  localparam int OP_MODE_LOW_POS  = 2;
  localparam int OP_MODE_HIGH_POS = 3;

  // Field positions in capcmp_control_reg
  localparam int FIRST_CAP_EN_POS  = 0;
  localparam int FIRST_TRIG_POS    = 1;
  localparam int SECOND_CAP_EN_POS = 2;

  // Field positions in prescaler_mode_reg
  localparam int CLK_SEL_LO_POS     = 0;
  localparam int CLK_SEL_HI_POS     = 1;
  localparam int IN_FIRST_LO_POS    = 4;
  localparam int IN_FIRST_HI_POS    = 5;
  localparam int IN_SECOND_LO_POS   = 6;
  localparam int IN_SECOND_HI_POS   = 7;

  // Pin index inside the edge carrier
  localparam int PIN_FIRST  = 0;
  localparam int PIN_SECOND = 1;

  // Byte enables that make a complete 16-bit word
  localparam logic [1:0] STRB_WORD16 = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    TDCC_MODE_STOP  = 2'b00,
    TDCC_MODE_FREE  = 2'b01,
    TDCC_MODE_EDGE  = 2'b10,
    TDCC_MODE_MATCH = 2'b11
  } tdcc_mode_t;

  typedef enum logic [1:0] {
    TDCC_EDGE_FALL = 2'b00,
    TDCC_EDGE_RISE = 2'b01,
    TDCC_EDGE_BAD  = 2'b10,
    TDCC_EDGE_BOTH = 2'b11
  } tdcc_edge_t;

  typedef enum logic [1:0] {
    TDCC_CLK_DIV1 = 2'b00,
    TDCC_CLK_DIV2 = 2'b01,
    TDCC_CLK_DIV4 = 2'b10,
    TDCC_CLK_PIN  = 2'b11
  } tdcc_clksel_t;

endpackage : tdcc_pkg

/* shared/tdcc_edge_if.sv */
// Carrier for synchronised pin edge pulses
`timescale 1ns/1ps
`default_nettype none
interface tdcc_edge_if;
  logic [1:0] rise;
  logic [1:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : tdcc_edge_if
`default_nettype wire

/* verilog/tdcc_pin_sync.sv */
// Three-stage pin synchroniser with edge detection for both timer inputs
`timescale 1ns/1ps
`default_nettype none
module tdcc_pin_sync
  import tdcc_pkg::*;
(
  // Clock and reset
  input  wire logic    aclk,
  input  wire logic    aresetn,
  // Raw pins
  input  wire logic    timer_input_first,
  input  wire logic    timer_input_second,
  // Edge pulses
  tdcc_edge_if.src     edges
);

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] stable;
    logic [1:0] rise;
    logic [1:0] fall;
  } tdcc_sync_t;

  tdcc_sync_t s_reg;
  tdcc_sync_t s_next;
  logic [1:0] agree;

  // A change counts only once stages two and three agree
  assign agree = ~(s_reg.sync2 ^ s_reg.sync3);

  always_comb begin
    s_next        = s_reg;
    s_next.sync1  = {timer_input_second, timer_input_first};
    s_next.sync2  = s_reg.sync1;
    s_next.sync3  = s_reg.sync2;
    s_next.stable = (agree & s_reg.sync3) | (~agree & s_reg.stable);
    s_next.rise   = agree & s_reg.sync3 & ~s_reg.stable;
    s_next.fall   = agree & ~s_reg.sync3 & s_reg.stable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign edges.rise = s_reg.rise;
  assign edges.fall = s_reg.fall;

endmodule : tdcc_pin_sync
`default_nettype wire

/* bench/tdcc_pin_model.sv */
// Behavioural source for the two timer input pins
`timescale 1ns/1ps
`default_nettype none
module tdcc_pin_model (
  // Clock
  input  wire logic aclk,
  // Toggle requests
  input  wire logic flip_first,
  input  wire logic flip_second,
  // Pins
  output logic      timer_input_first = 1'b0,
  output logic      timer_input_second = 1'b0
);
  ////////////////////////////////////////////////////////////////////////////
  // Pins only ever act as inputs, never as timer output
  // Late change mimics an asynchronous source against aclk
  always @(posedge aclk) begin
    if (flip_first) timer_input_first <= #3 ~timer_input_first;
    if (flip_second) timer_input_second <= #3 ~timer_input_second;
  end
endmodule : tdcc_pin_model
`default_nettype wire

/* bench/tdcc_timer_test.sv */
// Self-checking bench for the dual capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tdcc_timer_test
  import tdcc_pkg::*;
;
  typedef struct packed {logic chk; logic [33:0] v;} tdcc_note_t;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq1, irq2;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d, c0, c1;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              pin1, pin2, flip_first, flip_second;
  logic [31:0]       seed;
  tdcc_note_t        rq[$];
  tdcc_note_t        n;
  logic [1:0]        bq[$];
  int                failures, tests_run, cycles, i1, i2, b1, b2;
  ////////////////////////////////////////////////////////////////////////////
  tdcc_timer tdcc_timer_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_input_first(pin1), .timer_input_second(pin2),
    .match_first_irq(irq1), .match_second_irq(irq2));
  tdcc_pin_model tdcc_pin_model_inst (.aclk(aclk), .flip_first(flip_first),
    .flip_second(flip_second), .timer_input_first(pin1), .timer_input_second(pin2));
  always #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [31:0] md(input tdcc_mode_t m);
    return 32'(m) << OP_MODE_LOW_POS;
  endfunction : md
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    bq.push_back(er);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    do begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic c, input logic [33:0] e,
                    output logic [31:0] v);
    @(posedge aclk);
    rq.push_back('{c, e});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
  endtask : rd
  task automatic rx(input logic [7:0] a, input logic [15:0] v);
    rd(a, 1'b1, {RESP_OKAY, 16'h0000, v}, d);
  endtask : rx
  task automatic flip(input logic second);
    if (second) flip_second <= 1'b1;
    else flip_first <= 1'b1;
    @(posedge aclk);
    {flip_first, flip_second} <= 2'b00;
    tick(12);
  endtask : flip
  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard side: each answer takes the oldest note
  always @(posedge aclk) begin
    cycles++;
    if (aresetn) begin
      if (irq1 === 1'b1) i1++;
      if (irq2 === 1'b1) i2++;
      if (bvalid === 1'b1 && bready) `CHECK(bresp, bq.pop_front())
      if (rvalid === 1'b1 && rready) begin
        n = rq.pop_front();
        if (n.chk) `CHECK({rresp, rdata}, n.v)
      end
    end
    if (cycles == 80000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {flip_first, flip_second, awaddr, araddr, wdata, wstrb} = '0;
    seed = 32'hf1ec;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rx(ADDR_COUNT, CNT_ZERO);
    rx(ADDR_CAPCMP1, CNT_ZERO);
    rx(ADDR_CAPCMP2, CNT_ZERO);
    rd(8'h18, 1'b1, {RESP_DECERR, 32'h0}, d);
    wr(ADDR_COUNT, 32'h1234, 4'hf, RESP_SLVERR);
    wr(ADDR_CAPCMP1, 32'h0055, 4'h1, RESP_SLVERR);
    rx(ADDR_CAPCMP1, CNT_ZERO);
    seed = xs(seed);
    wr(ADDR_CAPCMP2, seed, 4'hf, RESP_OKAY);
    rx(ADDR_CAPCMP2, seed[15:0]);
    // Plain compares while free-running
    wr(ADDR_CAPCMP1, 32'h40, 4'hf, RESP_OKAY);
    wr(ADDR_CAPCMP2, 32'h30, 4'hf, RESP_OKAY);
    b1 = i1;
    b2 = i2;
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_FREE), 4'hf, RESP_OKAY);
    tick(100);
    `CHECK(i1 - b1, 1)
    `CHECK(i2 - b2, 1)
    rd(ADDR_COUNT, 1'b0, '0, d);
    `CHECK(d > 32'h40, 1'b1)
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_STOP), 4'hf, RESP_OKAY);
    rx(ADDR_COUNT, CNT_ZERO);
    // Clear on match keeps the count at or below the first register
    wr(ADDR_CAPCMP1, 32'h10, 4'hf, RESP_OKAY);
    b1 = i1;
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_MATCH), 4'hf, RESP_OKAY);
    tick(100);
    rd(ADDR_COUNT, 1'b0, '0, d);
    `CHECK(d <= 32'h10, 1'b1)
    `CHECK(i1 - b1 > 3, 1'b1)
    // Divided count clock; control writes without byte 0 are ignored
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_STOP), 4'hf, RESP_OKAY);
    wr(ADDR_PRESCALE, 32'h42, 4'hf, RESP_OKAY);
    rx(ADDR_PRESCALE, 16'h0042);
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_FREE), 4'h0, RESP_OKAY);
    rx(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_FREE), 4'hf, RESP_OKAY);
    rx(ADDR_MODE_CTRL, 16'(md(TDCC_MODE_FREE)));
    tick(40);
    rd(ADDR_COUNT, 1'b0, '0, d);
    `CHECK(d >= 32'h9 && d <= 32'hc, 1'b1)
    // Both registers capture; pin count clock never selected
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_STOP), 4'hf, RESP_OKAY);
    wr(ADDR_CC_CTRL, 32'h5, 4'hf, RESP_OKAY);
    wr(ADDR_PRESCALE, 32'h40, 4'hf, RESP_OKAY);
    b1 = i1;
    b2 = i2;
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_FREE), 4'hf, RESP_OKAY);
    tick(20);
    flip(1'b1);
    `CHECK(i1 - b1, 1)
    `CHECK(i2 - b2, 0)
    flip(1'b0);
    flip(1'b0);
    `CHECK(i2 - b2, 1)
    `CHECK(i1 - b1, 1)
    rd(ADDR_CAPCMP1, 1'b0, '0, c0);
    rd(ADDR_CAPCMP2, 1'b0, '0, d);
    `CHECK(c0 != 0 && d > c0, 1'b1)
    // Inverted first-pin edge into first register, silently
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_STOP), 4'hf, RESP_OKAY);
    wr(ADDR_CC_CTRL, 32'h7, 4'hf, RESP_OKAY);
    b1 = i1;
    b2 = i2;
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_FREE), 4'hf, RESP_OKAY);
    tick(60);
    flip(1'b0);
    `CHECK(i1 - b1, 0)
    `CHECK(i2 - b2, 0)
    rd(ADDR_CAPCMP1, 1'b0, '0, c1);
    `CHECK(c1 != c0, 1'b1)
    // Clear and restart on a first-pin falling edge
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_STOP), 4'hf, RESP_OKAY);
    wr(ADDR_CC_CTRL, 32'h0, 4'hf, RESP_OKAY);
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_EDGE), 4'hf, RESP_OKAY);
    tick(200);
    flip(1'b0);
    rd(ADDR_COUNT, 1'b0, '0, d);
    `CHECK(d < 32'h20, 1'b1)
    // Zero registers match once on the wrap
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_STOP), 4'hf, RESP_OKAY);
    wr(ADDR_CAPCMP1, 32'h0, 4'hf, RESP_OKAY);
    wr(ADDR_CAPCMP2, 32'h0, 4'hf, RESP_OKAY);
    b1 = i1;
    b2 = i2;
    wr(ADDR_MODE_CTRL, md(TDCC_MODE_FREE), 4'hf, RESP_OKAY);
    tick(65560);
    `CHECK(i1 - b1, 1)
    `CHECK(i2 - b2, 1)
    tally_and_finish();
  end
endmodule : tdcc_timer_test
`default_nettype wire
